/* rtl/ncc_consts.svh */
`ifndef NCC_CONSTS_SVH
`define NCC_CONSTS_SVH

`define NCC_PC_W 11
`define NCC_PM_WORDS 2048
`define NCC_DM_WORDS 128
`define NCC_STK_DEPTH 16
`define NCC_STK_W 13
`define NCC_SEC_W 16
`define NCC_TB_W 12

`define NCC_CLK_HZ 200000000
`define NCC_WATCH_HZ 32768
`define NCC_TICK_S 1

`define NCC_OFF_CTRL 12'h000
`define NCC_OFF_STATUS 12'h004
`define NCC_OFF_LD_ADDR 12'h008
`define NCC_OFF_LD_DATA 12'h00c
`define NCC_CTRL_RUN 0
`define NCC_CTRL_EVT_EXT 1

`define NCC_SP_RST 4'hf
`define NCC_PORT_RST 16'h00ff

`define NCC_VEC_EXT 11'h010
`define NCC_VEC_SEC 11'h020
`define NCC_VEC_TB 11'h030
`define NCC_VEC_TMR 11'h040

`define NCC_OP_ADS 8'h02
`define NCC_OP_INC_DIRECT_SKIP_ZERO 8'h12
`define NCC_OP_PUSH 8'h1c
`define NCC_OP_POP 8'h1d
`define NCC_OP_RT 8'h1e
`define NCC_OP_INL 8'h31
`define NCC_OP_INH 8'h32
`define NCC_OP_INM 8'h33
`define NCC_OP_DCL 8'h35
`define NCC_OP_DCH 8'h36
`define NCC_OP_PFX_D 8'h3d
`define NCC_OP_PFX_E 8'h3e
`define NCC_OP_STOP2 8'hb9

`define NCC_WAIT_CALL 2'd2
`define NCC_WAIT_RT 2'd3
`define NCC_WAIT_STK 2'd2

`endif

/* rtl/ncc_pkg.sv */
`include "ncc_consts.svh"

package ncc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXEC,
    ST_EXEC2,
    ST_WAIT,
    ST_STOP
  } ncc_st_e;

  typedef struct packed {
    ncc_st_e st;
    logic [`NCC_PC_W-1:0] pc;
    logic [7:0] op;
    logic [3:0] acc;
    logic c;
    logic [3:0] h;
    logic [3:0] l;
    logic [3:0] sp;
    logic skip;
    logic [1:0] wcnt;
    logic mei;
    logic eiex;
    logic eict;
    logic ext_pend;
    logic tmr_pend;
    logic sec_pend;
    logic tb_pend;
    logic [`NCC_TB_W-1:0] tb_cnt;
    logic [7:0] ct;
    logic [7:0] cmp;
    logic [`NCC_SEC_W-1:0] sec_cnt;
    logic int_q;
    logic cin_q;
    logic wx_q;
    logic run;
    logic evt_ext;
    logic [`NCC_PC_W-1:0] ld_addr;
    logic [15:0] port_lat;
    logic [15:0] port_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ncc_state_s;

endpackage : ncc_pkg

/* rtl/ncc_core.sv */
`timescale 1ns/1ps
`include "ncc_consts.svh"
module ncc_core #(
  parameter int WATCH_DIV = `NCC_WATCH_HZ * `NCC_TICK_S
) (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // Port lines.
  input wire logic [15:0] PORT_IN,
  output logic [15:0] PORT_OUT,
  output logic [15:0] PORT_OE,
  // Interrupt, event and watch crystal inputs.
  input wire logic EXT_IRQ_N,
  input wire logic EVENT_COUNT_PIN,
  input wire logic WATCH_CRYSTAL
);

  // The second divider counts in NCC_SEC_W bits and needs at least two edges.
  if (WATCH_DIV < 2 || WATCH_DIV > (1 << `NCC_SEC_W)) begin : g_bad_div
    $error("WATCH_DIV out of range");
  end

  localparam logic [`NCC_SEC_W-1:0] SEC_LAST =
    `NCC_SEC_W'(WATCH_DIV - 1);

  ncc_pkg::ncc_state_s s;
  ncc_pkg::ncc_state_s n;

  logic [7:0] prog_mem [`NCC_PM_WORDS];
  logic [3:0] data_mem [`NCC_DM_WORDS];
  logic [`NCC_STK_W-1:0] stack_mem [`NCC_STK_DEPTH];

  logic pm_we;
  logic dm_we;
  logic dm_we_hi;
  logic [6:0] dm_wa;
  logic [3:0] dm_wd;
  logic [3:0] dm_wd_hi;
  logic st_we;
  logic [`NCC_STK_W-1:0] st_wd;
  logic [7:0] b;
  logic [6:0] hl_a;
  logic [6:0] pair_a;
  logic [3:0] m;
  logic [3:0] m_d;
  logic [3:0] m_hi;
  logic [`NCC_STK_W-1:0] st_top;
  logic [4:0] sum;
  logic [2:0] pm_l;
  logic [2:0] pm_b;
  logic [3:0] pin_l;
  logic [3:0] pin_b;
  logic ext_evt;
  logic sec_evt;
  logic tb_ovf;
  logic cnt_evt;
  logic irq_any;
  logic acc_done;
  logic [7:0] ct_inc;

  function automatic logic [2:0] port_map(input logic [3:0] code);
    case (code)
      4'h0: port_map = 3'b100;
      4'h1: port_map = 3'b101;
      4'h3: port_map = 3'b110;
      4'h4: port_map = 3'b111;
      default: port_map = 3'b000;
    endcase
  endfunction : port_map

  function automatic logic two_byte(input logic [7:0] op);
    two_byte = (op == 8'h10) || (op == 8'h11) || (op == `NCC_OP_INC_DIRECT_SKIP_ZERO) ||
      (op == 8'h14) || (op == 8'h15) || (op == `NCC_OP_PFX_D) ||
      (op == `NCC_OP_PFX_E) || (op[7:3] == 5'b01000) ||
      (op[7:3] == 5'b10100);
  endfunction : two_byte

  always_comb begin
    n = s;
    pm_we = 1'b0;
    dm_we = 1'b0;
    dm_we_hi = 1'b0;
    dm_wa = 7'h00;
    dm_wd = 4'h0;
    dm_wd_hi = 4'h0;
    st_we = 1'b0;
    st_wd = '0;
    b = prog_mem[s.pc];
    hl_a = {s.h[2:0], s.l};
    pair_a = {s.h[2:0], s.l[3:1], 1'b0};
    m = data_mem[hl_a];
    m_d = data_mem[b[6:0]];
    m_hi = data_mem[pair_a | 7'h01];
    st_top = stack_mem[s.sp + 4'h1];
    sum = 5'h00;
    pm_l = port_map(s.l);
    pm_b = port_map(b[7:4]);
    pin_l = PORT_IN[{pm_l[1:0], 2'b00} +: 4];
    pin_b = PORT_IN[{pm_b[1:0], 2'b00} +: 4];
    ext_evt = s.int_q & ~EXT_IRQ_N;
    sec_evt = ~s.wx_q & WATCH_CRYSTAL && (s.sec_cnt == SEC_LAST);
    tb_ovf = &s.tb_cnt;
    cnt_evt = s.evt_ext ? (s.cin_q & ~EVENT_COUNT_PIN) : tb_ovf;
    irq_any = s.mei & ((s.ext_pend & s.eiex) | s.sec_pend | s.tb_pend |
      (s.tmr_pend & s.eict));
    acc_done = PSEL & PENABLE & s.pready;
    ct_inc = s.ct + 8'h01;

    case (s.st)
      ncc_pkg::ST_IDLE: begin
        if (s.run)
          n.st = ncc_pkg::ST_EXEC;
      end
      ncc_pkg::ST_EXEC: begin
        n.pc = s.pc + 11'h001;
        if (!s.run) begin
          n.st = ncc_pkg::ST_IDLE;
          n.pc = s.pc;
        end else if (s.skip) begin
          n.skip = 1'b0;
          if (two_byte(b)) begin
            n.op = 8'h00;
            n.st = ncc_pkg::ST_EXEC2;
          end
        end else if (irq_any) begin
          st_we = 1'b1;
          st_wd = {2'b00, s.pc};
          n.sp = s.sp - 4'h1;
          n.mei = 1'b0;
          n.wcnt = `NCC_WAIT_RT;
          n.st = ncc_pkg::ST_WAIT;
          if (s.ext_pend & s.eiex) begin
            n.ext_pend = 1'b0;
            n.pc = `NCC_VEC_EXT;
          end else if (s.sec_pend) begin
            n.sec_pend = 1'b0;
            n.pc = `NCC_VEC_SEC;
          end else if (s.tb_pend) begin
            n.tb_pend = 1'b0;
            n.pc = `NCC_VEC_TB;
          end else begin
            n.tmr_pend = 1'b0;
            n.pc = `NCC_VEC_TMR;
          end
        end else if (two_byte(b)) begin
          n.op = b;
          n.st = ncc_pkg::ST_EXEC2;
        end else begin
          sum = {1'b0, s.acc} + {1'b0, m};
          casez (b)
            8'b1001_????: n.acc = b[3:0];
            8'b1000_????: n.l = b[3:0];
            8'h21: n.acc = s.l;
            8'h2d: n.l = s.acc;
            8'h22: n.acc = s.h;
            8'h2e: n.h = s.acc;
            8'h38: n.acc = m;
            8'h2f, 8'h28: begin
              dm_we = 1'b1;
              dm_wa = hl_a;
              dm_wd = s.acc;
              // Only the exchange also loads the accumulator.
              if (b == 8'h28)
                n.acc = m;
            end
            `NCC_OP_INL: begin
              n.l = s.l + 4'h1;
              n.skip = (n.l == 4'h0);
            end
            `NCC_OP_INH: begin
              n.h = s.h + 4'h1;
              n.skip = (n.h == 4'h0);
            end
            `NCC_OP_INM, 8'h37: begin
              dm_we = 1'b1;
              dm_wa = hl_a;
              dm_wd = b[2] ? m - 4'h1 : m + 4'h1;
              n.skip = (dm_wd == (b[2] ? 4'hf : 4'h0));
            end
            `NCC_OP_DCL: begin
              n.l = s.l - 4'h1;
              n.skip = (n.l == 4'hf);
            end
            `NCC_OP_DCH: begin
              n.h = s.h - 4'h1;
              n.skip = (n.h == 4'hf);
            end
            8'b0101_01??: n.skip = s.acc[b[1:0]];
            8'b0101_00??: n.skip = pm_l[2] & pin_l[b[1:0]];
            8'b0110_00??, 8'b0111_00??: begin
              if (pm_l[2])
                n.port_lat[{pm_l[1:0], b[1:0]}] = b[4];
            end
            8'b0101_10??: n.skip = m[b[1:0]];
            8'b0110_10??, 8'b0111_10??: begin
              dm_we = 1'b1;
              dm_wa = hl_a;
              dm_wd = m;
              dm_wd[b[1:0]] = b[4];
            end
            8'h09: n.skip = s.c;
            8'h08: n.c = 1'b0;
            8'h07: n.c = 1'b1;
            `NCC_OP_ADS: begin
              n.acc = sum[3:0];
              n.skip = sum[4];
            end
            8'h03: begin
              sum = {1'b0, s.acc} + {1'b0, m} + {4'h0, s.c};
              {n.c, n.acc} = sum;
            end
            8'h0a: n.acc = s.acc + 4'ha;
            8'h0d: n.acc = s.acc & m;
            8'h05: n.acc = s.acc | m;
            8'h04: n.acc = s.acc ^ m;
            8'h0b: n.acc = ~s.acc;
            8'h16: n.skip = (s.acc == m);
            8'h0e: {n.c, n.acc} = {s.acc, s.c};
            8'b11??_????: n.pc = {s.pc[10:6], b[5:0]};
            `NCC_OP_RT: begin
              n.pc = st_top[`NCC_PC_W-1:0];
              n.sp = s.sp + 4'h1;
              n.wcnt = `NCC_WAIT_RT;
              n.st = ncc_pkg::ST_WAIT;
            end
            `NCC_OP_PUSH: begin
              st_we = 1'b1;
              st_wd = {s.c, s.acc, s.h, s.l};
              n.sp = s.sp - 4'h1;
              n.wcnt = `NCC_WAIT_STK;
              n.st = ncc_pkg::ST_WAIT;
            end
            `NCC_OP_POP: begin
              {n.c, n.acc, n.h, n.l} = st_top;
              n.sp = s.sp + 4'h1;
              n.wcnt = `NCC_WAIT_STK;
              n.st = ncc_pkg::ST_WAIT;
            end
            default: ;
          endcase
        end
      end
      ncc_pkg::ST_EXEC2: begin
        n.pc = s.pc + 11'h001;
        n.st = ncc_pkg::ST_EXEC;
        casez (s.op)
          8'h10: n.acc = m_d;
          8'h11: begin
            dm_we = 1'b1;
            dm_wa = b[6:0];
            dm_wd = s.acc;
          end
          `NCC_OP_INC_DIRECT_SKIP_ZERO: begin
            dm_we = 1'b1;
            dm_wa = b[6:0];
            dm_wd = m_d + 4'h1;
            n.skip = (dm_wd == 4'h0);
          end
          8'h14: begin
            dm_we = 1'b1;
            dm_we_hi = 1'b1;
            dm_wa = pair_a;
            {dm_wd_hi, dm_wd} = b;
          end
          8'h15: {n.h, n.l} = b;
          `NCC_OP_PFX_D: begin
            case (b)
              `NCC_OP_STOP2: n.st = ncc_pkg::ST_STOP;
              8'hc8: n.eiex = 1'b1;
              8'hcb: n.eict = 1'b1;
              8'hc4: n.eiex = 1'b0;
              8'hc7: n.eict = 1'b0;
              8'hc0: n.skip = s.eiex;
              8'hc3: n.skip = s.eict;
              8'h20: n.skip = s.ext_pend;
              8'hd2: n.skip = s.tmr_pend;
              8'h24: n.ext_pend = 1'b0;
              8'hd6: n.tmr_pend = 1'b0;
              default: begin
                if (pm_b[2]) begin
                  case (b[3:2])
                    2'b00: n.skip = pin_b[b[1:0]];
                    2'b01: n.port_lat[{pm_b[1:0], b[1:0]}] = 1'b0;
                    2'b10: n.port_lat[{pm_b[1:0], b[1:0]}] = 1'b1;
                    default: begin
                      if (b[0])
                        n.acc = pin_b;
                      else
                        n.port_lat[{pm_b[1:0], 2'b00} +: 4] = s.acc;
                    end
                  endcase
                end
              end
            endcase
          end
          `NCC_OP_PFX_E: begin
            casez (b)
              8'h59: begin
                dm_we = 1'b1;
                dm_we_hi = 1'b1;
                dm_wa = pair_a;
                {dm_wd_hi, dm_wd} = s.ct;
              end
              8'h51: begin
                n.cmp = {m_hi, data_mem[pair_a]};
                n.ct = 8'h00;
              end
              8'h60: n.mei = 1'b1;
              8'h61: n.mei = 1'b0;
              8'b0100_????: begin
                sum = {1'b0, s.acc} + {1'b0, b[3:0]};
                n.acc = sum[3:0];
                n.skip = sum[4];
              end
              8'b0000_????: n.skip = (s.acc == b[3:0]);
              default: ;
            endcase
          end
          8'b0100_0???: n.pc = {s.op[2:0], b};
          8'b1010_0???: begin
            st_we = 1'b1;
            st_wd = {2'b00, s.pc + 11'h001};
            n.pc = {s.op[2:0], b};
            n.sp = s.sp - 4'h1;
            n.wcnt = `NCC_WAIT_CALL;
            n.st = ncc_pkg::ST_WAIT;
          end
          default: ;
        endcase
      end
      ncc_pkg::ST_WAIT: begin
        n.wcnt = s.wcnt - 2'd1;
        if (s.wcnt == 2'd1)
          n.st = ncc_pkg::ST_EXEC;
      end
      ncc_pkg::ST_STOP: begin
        if (ext_evt | sec_evt)
          n.st = ncc_pkg::ST_EXEC;
      end
      default: n.st = ncc_pkg::ST_IDLE;
    endcase

    // Event sources; a set in the same cycle as a clear wins.
    n.int_q = EXT_IRQ_N;
    n.cin_q = EVENT_COUNT_PIN;
    n.wx_q = WATCH_CRYSTAL;
    n.tb_cnt = s.tb_cnt + 12'h001;
    if (tb_ovf)
      n.tb_pend = 1'b1;
    if (ext_evt)
      n.ext_pend = 1'b1;
    if (~s.wx_q & WATCH_CRYSTAL)
      n.sec_cnt = sec_evt ? '0 : s.sec_cnt + 1'b1;
    if (sec_evt)
      n.sec_pend = 1'b1;
    if (cnt_evt) begin
      n.ct = ct_inc;
      if (ct_inc == s.cmp) begin
        n.ct = 8'h00;
        n.tmr_pend = 1'b1;
      end
    end
    n.port_oe = ~n.port_lat;

    // APB slave with one wait state.
    n.pready = PSEL & PENABLE & ~s.pready;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (n.pready) begin
      case (PADDR)
        `NCC_OFF_CTRL: n.prdata = {30'h0, s.evt_ext, s.run};
        `NCC_OFF_STATUS: n.prdata = {11'h0, s.st == ncc_pkg::ST_STOP,
          s.sp, s.c, s.acc, s.pc};
        `NCC_OFF_LD_ADDR: n.prdata = {21'h0, s.ld_addr};
        `NCC_OFF_LD_DATA: n.prdata = {24'h0, prog_mem[s.ld_addr]};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (acc_done && PWRITE) begin
      case (PADDR)
        `NCC_OFF_CTRL: begin
          n.run = PWDATA[`NCC_CTRL_RUN];
          n.evt_ext = PWDATA[`NCC_CTRL_EVT_EXT];
        end
        `NCC_OFF_LD_ADDR: n.ld_addr = PWDATA[`NCC_PC_W-1:0];
        `NCC_OFF_LD_DATA: begin
          pm_we = 1'b1;
          n.ld_addr = s.ld_addr + 11'h001;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= '0;
      s.st <= ncc_pkg::ST_IDLE;
      s.sp <= `NCC_SP_RST;
      s.int_q <= 1'b1;
      s.port_lat <= `NCC_PORT_RST;
      s.port_oe <= ~`NCC_PORT_RST;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (pm_we)
      prog_mem[s.ld_addr] <= PWDATA[7:0];
    if (dm_we)
      data_mem[dm_wa] <= dm_wd;
    if (dm_we_hi)
      data_mem[dm_wa | 7'h01] <= dm_wd_hi;
    if (st_we)
      stack_mem[s.sp] <= st_wd;
  end

  assign PREADY = s.pready;
  assign PRDATA = s.prdata;
  assign PSLVERR = s.pslverr;
  assign PORT_OUT = s.port_lat;
  assign PORT_OE = s.port_oe;

endmodule : ncc_core

/* tb/ncc_core_chk.sv */
`timescale 1ns/1ps
module ncc_core_chk (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // Register bus.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // Port lines.
  input wire logic [15:0] PORT_OUT,
  input wire logic [15:0] PORT_OE
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);

  sequence first_access;
    PSEL && PENABLE && $past(PSEL && !PENABLE);
  endsequence

  sequence one_wait;
    !PREADY ##1 PREADY;
  endsequence

  apb_wait_a: assert property (first_access |-> one_wait)
    else $error("Bus answer not after one wait state.");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("Bus ready held too long.");
  ready_access_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("Bus ready outside access phase.");
  rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("Read data not zero while idle.");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("Bus error without ready.");
  unmapped_err_a: assert property (PREADY && PADDR > 12'h00c |-> PSLVERR)
    else $error("Unmapped access not refused.");
  mapped_ok_a: assert property
    (PREADY && PADDR <= 12'h00c && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("Mapped access refused.");
  port_oe_a: assert property (PORT_OE == ~PORT_OUT)
    else $error("Port enable does not mirror the latch.");
  reset_ports_a: assert property (disable iff (1'b0)
    !ARST_N |-> PORT_OUT == 16'h00ff && PORT_OE == 16'hff00)
    else $error("Ports not at reset levels.");
endmodule : ncc_core_chk

bind ncc_core ncc_core_chk u_chk (
  .CLK_SYS(CLK_SYS),
  .ARST_N(ARST_N),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PADDR(PADDR),
  .PREADY(PREADY),
  .PRDATA(PRDATA),
  .PSLVERR(PSLVERR),
  .PORT_OUT(PORT_OUT),
  .PORT_OE(PORT_OE)
);

/* tb/ncc_periph.sv */
`timescale 1ns/1ps
module ncc_periph (
  // Lines driven by the core.
  input wire logic [15:0] port_out,
  input wire logic [15:0] port_oe,
  // Requests from the bench.
  input wire logic [15:0] pull_low,
  input wire logic irq_req,
  input wire logic cnt_req,
  // Pin levels seen by the core.
  output logic [15:0] port_in,
  output logic ext_irq_n,
  output logic evt_pin
);
  // Lines are pulled up, so a line is low only while someone sinks it.
  assign port_in = ~((port_oe & ~port_out) | pull_low);
  // A request is a falling edge held low for the request's length.
  assign ext_irq_n = ~irq_req;
  assign evt_pin = ~cnt_req;
endmodule : ncc_periph

/* tb/ncc_core_bench.sv */
`timescale 1ns/1ps
module ncc_core_bench;
  logic clk;
  // Starts high so that the first assertion at time zero is a real edge.
  logic arst_n = 1'b1;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [15:0] port_in;
  logic [15:0] port_out;
  logic [15:0] port_oe;
  logic [15:0] pull_low;
  logic ext_n;
  logic evt;
  logic irq_req;
  logic cnt_req;
  logic wx_on;
  logic [2:0] wxc;
  logic [31:0] rd;
  logic er;
  logic [3:0] a;
  logic [3:0] b;
  int seed;
  int n_mismatch;
  int checked;

`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("Error at %0t: got %h, expected %h", $time, g, e); \
  end \
end

  ncc_core #(.WATCH_DIV(4)) u_ncc_core (
    .CLK_SYS(clk),
    .ARST_N(arst_n),
    .PSEL(psel),
    .PENABLE(penable),
    .PWRITE(pwrite),
    .PADDR(paddr),
    .PWDATA(pwdata),
    .PREADY(pready),
    .PRDATA(prdata),
    .PSLVERR(pslverr),
    .PORT_IN(port_in),
    .PORT_OUT(port_out),
    .PORT_OE(port_oe),
    .EXT_IRQ_N(ext_n),
    .EVENT_COUNT_PIN(evt),
    .WATCH_CRYSTAL(wx_on & wxc[2])
  );

  ncc_periph u_ncc_periph (
    .port_out(port_out),
    .port_oe(port_oe),
    .pull_low(pull_low),
    .irq_req(irq_req),
    .cnt_req(cnt_req),
    .port_in(port_in),
    .ext_irq_n(ext_n),
    .evt_pin(evt)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    wxc <= wxc + 3'h1;
  end

  // A carry skips the reload of six, so the sum stays.
  function automatic logic [3:0] ads_exp(logic [3:0] x, logic [3:0] y);
    logic [4:0] s;
    s = {1'b0, x} + {1'b0, y};
    return s[4] ? s[3:0] : 4'h6;
  endfunction : ads_exp

  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task ld(input logic [10:0] ad, input logic [95:0] v, input int n);
    apb(1'b1, 12'h008, {21'h0, ad});
    for (int i = n - 1; i >= 0; i--) begin
      apb(1'b1, 12'h00c, {24'h0, v[8*i +: 8]});
    end
  endtask : ld

  task start(input logic [95:0] v, input int n);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(port_out, 16'h00ff)
    arst_n <= 1'b1;
    ld(11'h000, v, n);
  endtask : start

  task go(input logic ev);
    apb(1'b1, 12'h000, {30'h0, ev, 1'b1});
    repeat (40) @(posedge clk);
  endtask : go

  task st(input logic [3:0] acc, input logic [3:0] sp, input logic c,
          input logic s = 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[20:11], {s, sp, c, acc})
  endtask : st

  task run(input logic [95:0] v, input int n, input logic [3:0] acc,
           input logic [3:0] sp, input logic c, input logic s = 1'b0);
    start(v, n);
    go(1'b0);
    st(acc, sp, c, s);
  endtask : run

  task pulse(input logic ev);
    cnt_req <= ev;
    irq_req <= !ev;
    repeat (4) @(posedge clk);
    cnt_req <= 1'b0;
    irq_req <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : pulse

  task report_and_stop;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    seed = 51267;
    n_mismatch = 0;
    checked = 0;
    arst_n <= 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pull_low = 16'h0;
    irq_req = 1'b0;
    cnt_req = 1'b0;
    wx_on = 1'b0;
    wxc = 3'h0;
    run(96'h958f3191c4, 5, 4'h5, 4'hf, 1'b0);
    run(96'h9f2e3291c4, 5, 4'hf, 4'hf, 1'b0);
    run(96'h9f2f3391c4, 5, 4'hf, 4'hf, 1'b0);
    run(96'h95803591c4, 5, 4'h5, 4'hf, 1'b0);
    run(96'h95833591c4, 5, 4'h1, 4'hf, 1'b0);
    run(96'h953691c3, 4, 4'h5, 4'hf, 1'b0);
    run(96'h9f3e4194c4, 5, 4'h0, 4'hf, 1'b0);
    run(96'h923e4194c4, 5, 4'h4, 4'hf, 1'b0);
    run(96'ha00693c30000971e, 8, 4'h3, 4'hf, 1'b0);
    run(96'ha0040000c4, 5, 4'h0, 4'he, 1'b0);
    run(96'h95071c90081dc6, 7, 4'h5, 4'hf, 1'b1);
    run(96'h95071c9008c5, 6, 4'h0, 4'he, 1'b0);
    run(96'h9f1105120591c6, 7, 4'hf, 4'hf, 1'b0);
    run(96'h902f7a385a91c6, 7, 4'h4, 4'hf, 1'b0);
    run(96'h9f2f6a385a92c6, 7, 4'h2, 4'hf, 1'b0);
    repeat (4) begin
      a = 4'($random(seed));
      b = 4'($random(seed));
      run({48'h0, 4'h9, a, 8'h2f, 4'h9, b, 24'h0296c5}, 6,
          ads_exp(a, b), 4'hf, 1'b0);
    end
    repeat (2) begin
      b = 4'($random(seed));
      pull_low <= {14'h0, b[0], 1'b0};
      run(96'h953d0191c4, 5, b[0] ? 4'h1 : 4'h5, 4'hf, 1'b0);
    end
    pull_low <= 16'h0;
    run(96'h3d043d383d4bc6, 7, 4'h0, 4'hf, 1'b0);
    `CHK(port_out, 16'h81fe)
    start(96'h3e603dc895c5, 6);
    ld(11'h010, 96'h9ad1, 2);
    go(1'b0);
    st(4'h5, 4'hf, 1'b0);
    pulse(1'b0);
    st(4'ha, 4'he, 1'b0);
    start(96'h3e603dc495c5, 6);
    ld(11'h010, 96'h9ad1, 2);
    go(1'b0);
    pulse(1'b0);
    st(4'h5, 4'hf, 1'b0);
    start(96'h14033e513e603dcb95c9, 10);
    ld(11'h040, 96'h9cc1, 2);
    go(1'b1);
    pulse(1'b1);
    pulse(1'b1);
    st(4'h5, 4'hf, 1'b0);
    pulse(1'b1);
    st(4'hc, 4'he, 1'b0);
    start(96'h3e6095c3, 4);
    ld(11'h030, 96'h9bf1, 2);
    go(1'b0);
    repeat (4200) @(posedge clk);
    st(4'hb, 4'he, 1'b0);
    run(96'h3db997c3, 4, 4'h0, 4'hf, 1'b0, 1'b1);
    st(4'h0, 4'hf, 1'b0, 1'b1);
    pulse(1'b0);
    st(4'h7, 4'hf, 1'b0);
    run(96'h3db997c3, 4, 4'h0, 4'hf, 1'b0, 1'b1);
    wx_on <= 1'b1;
    repeat (60) @(posedge clk);
    st(4'h7, 4'hf, 1'b0);
    wx_on <= 1'b0;
    apb(1'b1, 12'h010, 32'h1);
    `CHK(er, 1'b1)
    apb(1'b0, 12'h010, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    report_and_stop;
  end
endmodule : ncc_core_bench
